// File: verilog/nsf_pkg.sv
/*
 * shared constants and carrier types for the stream-mode framer
 * assumes the framer clock is the carrier-derived clock (one tick per fc cycle)
 */
package nsf_pkg;
    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [5:0] ADDR_IO_CFG1     = 6'h00;
    localparam logic [5:0] ADDR_IO_CFG2     = 6'h01;
    localparam logic [5:0] ADDR_OP_CTRL     = 6'h02;
    localparam logic [5:0] ADDR_MODE_SEL    = 6'h03;
    localparam logic [5:0] ADDR_TYPE_A      = 6'h05;
    localparam logic [5:0] ADDR_STREAM_OPTS = 6'h08;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_IO_CFG1      = 8'h08;
    localparam logic [7:0] RST_IO_CFG2      = 8'h00;
    localparam logic [7:0] RST_OP_CTRL      = 8'h00;
    localparam logic [7:0] RST_MODE_SEL     = 8'h00;
    localparam logic [7:0] RST_TYPE_A       = 8'h00;
    localparam logic [7:0] RST_STREAM_OPTS  = 8'h00;
    localparam logic [7:0] READ_UNMAPPED    = 8'h00;
    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int         MODE_OM_LSB      = 3;
    localparam logic [3:0] OM_STREAM_SUBC   = 4'hE;
    localparam logic [3:0] OM_STREAM_BPSK   = 4'hF;
    localparam int         TYPE_A_CUST_LO   = 6;
    localparam int         TYPE_A_CUST_HI   = 7;
    // ----------------------------------------------------------------
    // timing counts and limits, base periods in carrier cycles
    // ----------------------------------------------------------------
    localparam logic [6:0] SUBC_BASE_PERIOD = 7'h40;
    localparam logic [6:0] BPSK_BASE_PERIOD = 7'h10;
    localparam logic [1:0] BPSK_SCF_MAX     = 2'h2;
    localparam logic [1:0] SUBC_SCP_MIN     = 2'h1;
    localparam logic [7:0] TX_BASE_PERIOD   = 8'h80;
    localparam logic [3:0] SUBC_END_IDLE    = 4'h8;
    localparam logic [2:0] MIN_EDGES        = 3'h2;
    localparam logic [2:0] LAST_BIT         = 3'h7;
    // ----------------------------------------------------------------
    // carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       am_sel;
        logic [1:0] scf;
        logic [1:0] scp;
        logic [2:0] stx;
    } nsf_opts_t;

    typedef struct packed {
        logic done;
        logic present;
        logic phase;
    } nsf_period_t;

    typedef enum logic [1:0] {
        RX_OFF  = 2'b00,
        RX_HUNT = 2'b01,
        RX_RUN  = 2'b10
    } nsf_rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_LOAD = 2'b01,
        TX_SEND = 2'b10
    } nsf_tx_state_t;
endpackage

// File: verilog/nsf_period_det.sv
/*
 * reporting-period detector: syncs the demodulated sub-carrier pin,
 * counts its edges and samples its phase once per reporting period
 * assumes sub_len and rep_len are stable while run is high
 */
`timescale 1ns/1ps
module nsf_period_det
    import nsf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        run,
    input  wire logic [6:0]  sub_len,
    input  wire logic [9:0]  rep_len,
    input  wire logic        rx_pin,
    output nsf_period_t      period
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic        sync1_q;
    logic        sync2_q;
    logic        prev_q;
    logic [9:0]  cnt_q;
    logic [9:0]  cnt_d;
    logic [2:0]  edges_q;
    logic [2:0]  edges_d;
    logic        phase_q;
    logic        phase_d;
    nsf_period_t per_q;
    nsf_period_t per_d;

    assign period = per_q;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        cnt_d   = cnt_q;
        edges_d = edges_q;
        phase_d = phase_q;
        per_d   = '0;
        if (!run) begin
            cnt_d   = '0;
            edges_d = '0;
        end else begin
            if ((sync2_q != prev_q) && (edges_q != 3'h7)) begin
                edges_d = edges_q + 3'h1;
            end
            if (cnt_q == {5'h00, sub_len[6:2]}) begin
                phase_d = sync2_q;
            end
            if (cnt_q >= rep_len - 10'h001) begin
                per_d.present = (edges_d >= MIN_EDGES);
                cnt_d         = '0;
                edges_d       = '0;
                per_d.done    = 1'b1;
                per_d.phase   = phase_d;
            end else begin
                cnt_d = cnt_q + 10'h001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            cnt_q   <= '0;
            edges_q <= '0;
            phase_q <= 1'b0;
            per_q   <= '0;
        end else begin
            sync1_q <= rx_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            cnt_q   <= cnt_d;
            edges_q <= edges_d;
            phase_q <= phase_d;
            per_q   <= per_d;
        end
    end
endmodule

// File: verilog/nsf_framer.sv
/*
 * stream-mode framer: register file, stream receive packing and
 * stream transmit bit timing
 * assumes clk is the carrier clock, the fifo on the transmit side is
 * show-ahead, and rst_n low is the power-up reset
 */
//
// Contract
// - earliest bit goes to byte LSB
// - mode and options registers steer stream
// - subcarrier mode fc/64 to fc/8
// - subcarrier reporting period two to eight
// - first present period starts and writes
// - subcarrier bit is presence per period
// - subcarrier ends after over eight idle
// - scf 01 is fc/32, scp 10 four
// - bpsk fc/16 to fc/4, one-eight periods
// - bpsk bit is phase versus first
// - bpsk ends on first empty period
// - bpsk scf 01 fc/8, scp 01 two
// - tx bit held, one modulates carrier
// - stx 000 gives 128 carrier cycles
// - transmit commands start stream sending
// - type a bits 6,7 enable custom
// - set default spares registers 00-02
`timescale 1ns/1ps
module nsf_framer
    import nsf_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [5:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        cmd_set_default,
    input  wire logic        cmd_tx_crc,
    input  wire logic        cmd_tx_nocrc,
    input  wire logic        rx_sub,
    input  wire logic [7:0]  tx_fifo_data,
    input  wire logic        tx_fifo_avail,
    output logic             tx_fifo_rd,
    output logic      [7:0]  rx_fifo_wdata,
    output logic             rx_fifo_wr,
    output logic             irq_rx_start,
    output logic             irq_rx_end,
    output logic             irq_tx_end,
    output logic             tx_mod,
    output logic             tx_am,
    output logic             type_a_custom_en,
    output logic             stream_sel,
    output logic             rx_active
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]    io1_q, io1_d, io2_q, io2_d, opc_q, opc_d;
    logic [7:0]    mode_q, mode_d, typea_q, typea_d;
    nsf_opts_t     opts_q, opts_d;
    logic [7:0]    rdata_q, rdata_d;
    logic          cust_q, cust_d, ssel_q, ssel_d, am_q, am_d;

    always_comb begin
        io1_d   = io1_q;
        io2_d   = io2_q;
        opc_d   = opc_q;
        mode_d  = mode_q;
        typea_d = typea_q;
        opts_d  = opts_q;
        rdata_d = rdata_q;
        if (cmd_set_default) begin
            mode_d  = RST_MODE_SEL;
            typea_d = RST_TYPE_A;
            opts_d  = RST_STREAM_OPTS;
        end else if (reg_wr) begin
            if (reg_addr == ADDR_IO_CFG1) begin
                io1_d = reg_wdata;
            end else if (reg_addr == ADDR_IO_CFG2) begin
                io2_d = reg_wdata;
            end else if (reg_addr == ADDR_OP_CTRL) begin
                opc_d = reg_wdata;
            end else if (reg_addr == ADDR_MODE_SEL) begin
                mode_d = reg_wdata;
            end else if (reg_addr == ADDR_TYPE_A) begin
                typea_d = reg_wdata;
            end else if (reg_addr == ADDR_STREAM_OPTS) begin
                opts_d = reg_wdata;
            end
        end
        if (reg_rd) begin
            if (reg_addr == ADDR_IO_CFG1) begin
                rdata_d = io1_q;
            end else if (reg_addr == ADDR_IO_CFG2) begin
                rdata_d = io2_q;
            end else if (reg_addr == ADDR_OP_CTRL) begin
                rdata_d = opc_q;
            end else if (reg_addr == ADDR_MODE_SEL) begin
                rdata_d = mode_q;
            end else if (reg_addr == ADDR_TYPE_A) begin
                rdata_d = typea_q;
            end else if (reg_addr == ADDR_STREAM_OPTS) begin
                rdata_d = opts_q;
            end else begin
                rdata_d = READ_UNMAPPED;
            end
        end
        cust_d = typea_d[TYPE_A_CUST_HI] & typea_d[TYPE_A_CUST_LO];
        ssel_d = is_stream(mode_d);
        am_d   = opts_d.am_sel;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            io1_q   <= RST_IO_CFG1;
            io2_q   <= RST_IO_CFG2;
            opc_q   <= RST_OP_CTRL;
            mode_q  <= RST_MODE_SEL;
            typea_q <= RST_TYPE_A;
            opts_q  <= RST_STREAM_OPTS;
            rdata_q <= 8'h00;
            cust_q  <= 1'b0;
            ssel_q  <= 1'b0;
            am_q    <= 1'b0;
        end else begin
            io1_q   <= io1_d;
            io2_q   <= io2_d;
            opc_q   <= opc_d;
            mode_q  <= mode_d;
            typea_q <= typea_d;
            opts_q  <= opts_d;
            rdata_q <= rdata_d;
            cust_q  <= cust_d;
            ssel_q  <= ssel_d;
            am_q    <= am_d;
        end
    end
    assign reg_rdata        = rdata_q;
    assign type_a_custom_en = cust_q;
    assign stream_sel       = ssel_q;
    assign tx_am            = am_q;

    // ----------------------------------------------------------------
    // option decoding
    // ----------------------------------------------------------------
    function automatic logic is_stream(input logic [7:0] m);
        is_stream = (m[MODE_OM_LSB +: 4] == OM_STREAM_SUBC) || (m[MODE_OM_LSB +: 4] == OM_STREAM_BPSK);
    endfunction

    logic       bpsk;
    logic [1:0] scf_eff;
    logic [1:0] scp_eff;
    logic [6:0] sub_len;
    logic [9:0] rep_len;
    logic [7:0] bit_len;

    always_comb begin
        bpsk    = (mode_q[MODE_OM_LSB +: 4] == OM_STREAM_BPSK);
        scf_eff = opts_q.scf;
        scp_eff = opts_q.scp;
        if (bpsk) begin
            if (scf_eff > BPSK_SCF_MAX) begin
                scf_eff = BPSK_SCF_MAX;
            end
            sub_len = BPSK_BASE_PERIOD >> scf_eff;
        end else begin
            if (scp_eff < SUBC_SCP_MIN) begin
                scp_eff = SUBC_SCP_MIN;
            end
            sub_len = SUBC_BASE_PERIOD >> scf_eff;
        end
        rep_len = {3'h0, sub_len} << scp_eff;
        bit_len = TX_BASE_PERIOD >> opts_q.stx;
    end

    // ----------------------------------------------------------------
    // stream receive
    // ----------------------------------------------------------------
    nsf_rx_state_t rx_q, rx_d;
    nsf_period_t   per;
    logic          ref_q, ref_d;
    logic [3:0]    idle_q, idle_d;
    logic [7:0]    byte_q, byte_d;
    logic [2:0]    nbit_q, nbit_d;
    logic [7:0]    wdata_q, wdata_d;
    logic          wr_q, wr_d, rxs_q, rxs_d, rxe_q, rxe_d;
    logic          push, push_bit, flush, rx_allow;
    nsf_tx_state_t tx_q, tx_d;

    assign rx_allow = ssel_q && (tx_q == TX_IDLE);

    nsf_period_det u_det (
        .clk     (clk),
        .rst_n   (rst_n),
        .run     (rx_q != RX_OFF),
        .sub_len (sub_len),
        .rep_len (rep_len),
        .rx_pin  (rx_sub),
        .period  (per)
    );

    always_comb begin
        rx_d     = rx_q;
        ref_d    = ref_q;
        idle_d   = idle_q;
        byte_d   = byte_q;
        nbit_d   = nbit_q;
        wdata_d  = wdata_q;
        wr_d     = 1'b0;
        rxs_d    = 1'b0;
        rxe_d    = 1'b0;
        push     = 1'b0;
        push_bit = 1'b0;
        flush    = 1'b0;
        case (rx_q)
            RX_OFF: begin
                byte_d = '0;
                nbit_d = '0;
                if (rx_allow) begin
                    rx_d = RX_HUNT;
                end
            end
            RX_HUNT: begin
                if (!rx_allow) begin
                    rx_d = RX_OFF;
                end else if (per.done && per.present) begin
                    rxs_d    = 1'b1;
                    ref_d    = per.phase;
                    idle_d   = '0;
                    push     = 1'b1;
                    push_bit = !bpsk;
                    rx_d     = RX_RUN;
                end
            end
            RX_RUN: begin
                if (!rx_allow) begin
                    rx_d = RX_OFF;
                end else if (per.done) begin
                    if (bpsk) begin
                        if (!per.present) begin
                            flush = 1'b1;
                        end else begin
                            push     = 1'b1;
                            push_bit = per.phase ^ ref_q;
                        end
                    end else if (per.present) begin
                        idle_d   = '0;
                        push     = 1'b1;
                        push_bit = 1'b1;
                    end else if (idle_q == SUBC_END_IDLE) begin
                        flush = 1'b1;
                    end else begin
                        idle_d   = idle_q + 4'h1;
                        push     = 1'b1;
                        push_bit = 1'b0;
                    end
                end
            end
            default: begin
                rx_d = RX_OFF;
            end
        endcase
        if (push) begin
            byte_d[nbit_q] = push_bit;
            if (nbit_q == LAST_BIT) begin
                wdata_d = byte_d;
                wr_d    = 1'b1;
                byte_d  = '0;
                nbit_d  = '0;
            end else begin
                nbit_d = nbit_q + 3'h1;
            end
        end
        if (flush) begin
            rxe_d = 1'b1;
            rx_d  = RX_HUNT;
            if (nbit_q != 3'h0) begin
                wdata_d = byte_q;
                wr_d    = 1'b1;
            end
            byte_d = '0;
            nbit_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rx_q    <= RX_OFF;
            ref_q   <= 1'b0;
            idle_q  <= '0;
            byte_q  <= '0;
            nbit_q  <= '0;
            wdata_q <= '0;
            wr_q    <= 1'b0;
            rxs_q   <= 1'b0;
            rxe_q   <= 1'b0;
        end else begin
            rx_q    <= rx_d;
            ref_q   <= ref_d;
            idle_q  <= idle_d;
            byte_q  <= byte_d;
            nbit_q  <= nbit_d;
            wdata_q <= wdata_d;
            wr_q    <= wr_d;
            rxs_q   <= rxs_d;
            rxe_q   <= rxe_d;
        end
    end

    assign rx_fifo_wdata = wdata_q;
    assign rx_fifo_wr    = wr_q;
    assign irq_rx_start  = rxs_q;
    assign irq_rx_end    = rxe_q;
    assign rx_active     = (rx_q == RX_RUN);

    // ----------------------------------------------------------------
    // stream transmit
    // ----------------------------------------------------------------
    logic [7:0] sh_q, sh_d;
    logic [2:0] tbit_q, tbit_d;
    logic [7:0] tcnt_q, tcnt_d;
    logic       mod_q, mod_d, rd_q, rd_d, txe_q, txe_d, load;

    always_comb begin
        tx_d   = tx_q;
        sh_d   = sh_q;
        tbit_d = tbit_q;
        tcnt_d = tcnt_q;
        mod_d  = mod_q;
        rd_d   = 1'b0;
        txe_d  = 1'b0;
        load   = 1'b0;
        case (tx_q)
            TX_IDLE: begin
                mod_d = 1'b0;
                if (ssel_q && (cmd_tx_crc || cmd_tx_nocrc)) begin
                    tx_d = TX_LOAD;
                end
            end
            TX_LOAD: begin
                load = 1'b1;
            end
            TX_SEND: begin
                if (tcnt_q == bit_len - 8'h01) begin
                    tcnt_d = '0;
                    if (tbit_q == LAST_BIT) begin
                        load = 1'b1;
                    end else begin
                        tbit_d = tbit_q + 3'h1;
                        mod_d  = sh_q[tbit_d];
                    end
                end else begin
                    tcnt_d = tcnt_q + 8'h01;
                end
            end
            default: begin
                tx_d = TX_IDLE;
            end
        endcase
        if (load) begin
            if (tx_fifo_avail) begin
                rd_d   = 1'b1;
                sh_d   = tx_fifo_data;
                tbit_d = '0;
                tcnt_d = '0;
                mod_d  = tx_fifo_data[0];
                tx_d   = TX_SEND;
            end else begin
                txe_d = 1'b1;
                mod_d = 1'b0;
                tx_d  = TX_IDLE;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_q   <= TX_IDLE;
            sh_q   <= '0;
            tbit_q <= '0;
            tcnt_q <= '0;
            mod_q  <= 1'b0;
            rd_q   <= 1'b0;
            txe_q  <= 1'b0;
        end else begin
            tx_q   <= tx_d;
            sh_q   <= sh_d;
            tbit_q <= tbit_d;
            tcnt_q <= tcnt_d;
            mod_q  <= mod_d;
            rd_q   <= rd_d;
            txe_q  <= txe_d;
        end
    end

    assign tx_mod     = mod_q;
    assign tx_fifo_rd = rd_q;
    assign irq_tx_end = txe_q;
endmodule

// File: tb/nsf_tag_model.sv
/*
 * tag model: square-wave sub-carrier on the demodulated pin
 * assumes the bench drives en, inv and half away from the rising edge
 */
`timescale 1ns/1ps
module nsf_tag_model (
    input  wire logic       clk,
    input  wire logic       en,
    input  wire logic       inv,
    input  wire logic [5:0] half,
    output logic            rx_sub
);
    // ------
    // sub-carrier generator
    // ------
    logic [5:0] cnt_q = 6'h00;
    logic       wav_q = 1'b0;
    always @(posedge clk) begin
        if (cnt_q + 6'h01 >= half) begin
            cnt_q <= 6'h00;
            wav_q <= ~wav_q;
        end else begin
            cnt_q <= cnt_q + 6'h01;
        end
    end
    // no sub-carrier gives a steady low pin
    assign rx_sub = en & (wav_q ^ inv);
endmodule

// File: tb/nsf_framer_chk.sv
/*
 * checker on the framer ports: derived outputs and transmit timing
 * assumes it is bound to nsf_framer, one clock domain
 */
`timescale 1ns/1ps
module nsf_framer_chk
    import nsf_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       cmd_set_default,
    input wire logic [7:0] tx_fifo_data,
    input wire logic       tx_fifo_rd,
    input wire logic       irq_rx_start,
    input wire logic       irq_tx_end,
    input wire logic       tx_mod,
    input wire logic       tx_am,
    input wire logic       type_a_custom_en,
    input wire logic       stream_sel
);
    // ------
    // register shadows and bit-time counter
    // ------
    logic [7:0]  md_q, ta_q, op_q, md_d, ta_d, op_d;
    logic [10:0] cnt_q, cnt_d;
    logic [10:0] blen;
    logic        wr_ok;
    assign wr_ok = reg_wr & ~cmd_set_default;
    assign blen  = 11'h080 >> op_q[2:0];
    always_comb begin
        md_d  = md_q;
        ta_d  = ta_q;
        op_d  = op_q;
        cnt_d = tx_fifo_rd ? 11'h000 : cnt_q + 11'h001;
        if (cmd_set_default) begin
            md_d = 8'h00;
            ta_d = 8'h00;
            op_d = 8'h00;
        end else if (reg_wr) begin
            md_d = (reg_addr == ADDR_MODE_SEL) ? reg_wdata : md_q;
            ta_d = (reg_addr == ADDR_TYPE_A) ? reg_wdata : ta_q;
            op_d = (reg_addr == ADDR_STREAM_OPTS) ? reg_wdata : op_q;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            md_q  <= 8'h00;
            ta_q  <= 8'h00;
            op_q  <= 8'h00;
            cnt_q <= 11'h000;
        end else begin
            md_q  <= md_d;
            ta_q  <= ta_d;
            op_q  <= op_d;
            cnt_q <= cnt_d;
        end
    end
    // ------
    // assertions
    // ------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence wr_to(logic [5:0] a);
        wr_ok && reg_addr == a;
    endsequence
    sequence tx_off;
        !tx_mod ##1 !irq_tx_end;
    endsequence
    cust_en_a: assert property (wr_to(ADDR_TYPE_A) |-> ##[1:2] type_a_custom_en == &ta_q[7:6])
        else $error("custom frame enable wrong");
    am_type_a: assert property (wr_to(ADDR_STREAM_OPTS) |-> ##[1:2] tx_am == op_q[7])
        else $error("modulation type wrong");
    mode_sel_a: assert property (wr_to(ADDR_MODE_SEL) |-> ##[1:2] stream_sel == (md_q[6:4] == 3'h7))
        else $error("stream select wrong");
    dflt_clr_a: assert property (cmd_set_default |-> ##2 !(stream_sel | tx_am | type_a_custom_en))
        else $error("set default left outputs set");
    bit_time_a: assert property ($changed(tx_mod) && !tx_fifo_rd |-> (cnt_q + 11'h001) % blen == 11'h000)
        else $error("transmit bit time wrong");
    tx_lsb_a: assert property (tx_fifo_rd |-> tx_mod == tx_fifo_data[0])
        else $error("first sent bit not lsb");
    tx_end_a: assert property (irq_tx_end |-> ##[0:1] tx_off)
        else $error("modulator on at transmit end");
    rx_start_a: assert property (irq_rx_start |=> !irq_rx_start)
        else $error("receive start not a pulse");
endmodule

bind nsf_framer nsf_framer_chk chk (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .cmd_set_default, .tx_fifo_data, .tx_fifo_rd,
    .irq_rx_start, .irq_tx_end, .tx_mod, .tx_am, .type_a_custom_en, .stream_sel
);

// File: tb/nsf_framer_test.sv
/*
 * bench: registers, set default, both receive schemes, transmit
 * assumes the checker binds itself to the framer
 */
`timescale 1ns/1ps
module nsf_framer_test
    import nsf_pkg::*;
;
    logic       clk, rst_n, reg_wr, reg_rd, dflt, crc, nocrc, en, inv, rx_sub;
    logic       fifo_rd, avail, popq, rx_wr, irs, ire, ite, mod, am, cust, ssel, act;
    logic [5:0] addr, half;
    logic [7:0] wdata, rdata, rx_d, fifo_d;
    logic [7:0] txq[$];
    logic [7:0] rxq[$];
    int         bad_count = 0;
    int         total_checks = 0;
    int         cyc = 0;
    nsf_framer uut (
        .clk, .rst_n, .reg_addr(addr), .reg_wdata(wdata), .reg_wr, .reg_rd, .reg_rdata(rdata),
        .cmd_set_default(dflt), .cmd_tx_crc(crc), .cmd_tx_nocrc(nocrc), .rx_sub,
        .tx_fifo_data(fifo_d), .tx_fifo_avail(avail), .tx_fifo_rd(fifo_rd), .rx_fifo_wdata(rx_d),
        .rx_fifo_wr(rx_wr), .irq_rx_start(irs), .irq_rx_end(ire), .irq_tx_end(ite), .tx_mod(mod),
        .tx_am(am), .type_a_custom_en(cust), .stream_sel(ssel), .rx_active(act)
    );
    nsf_tag_model tag (.clk, .en, .inv, .half, .rx_sub);
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // ------
    // fifo models and cycle limit
    // ------
    always @(negedge clk) begin
        if (popq) void'(txq.pop_front());
        popq = fifo_rd;
        fifo_d = (txq.size() != 0) ? txq[0] : 8'h00;
        avail = txq.size() != 0;
        if (rx_wr) rxq.push_back(rx_d);
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            summarize();
        end
    end
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask
    task rdc(input logic [5:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        chk(rdata, e);
    endtask
    task cmd(input int k);
        @(negedge clk);
        {dflt, crc, nocrc} = 3'b100 >> k;
        @(negedge clk);
        {dflt, crc, nocrc} = 3'b000;
    endtask
    // ------
    // scenarios
    // ------
    task t_regs;
        rdc(ADDR_IO_CFG1, 8'h08);
        rdc(ADDR_MODE_SEL, 8'h00);
        rdc(ADDR_STREAM_OPTS, 8'h00);
        wr(6'h3F, 8'hFF);
        rdc(6'h3F, 8'h00);
        wr(ADDR_TYPE_A, 8'h40);
        chk(cust, 1'b0);
        wr(ADDR_TYPE_A, 8'hC0);
        chk(cust, 1'b1);
        rdc(ADDR_TYPE_A, 8'hC0);
        $display("test regs done");
    endtask
    task t_dflt;
        wr(ADDR_IO_CFG2, 8'h5A);
        wr(ADDR_MODE_SEL, 8'h70);
        wr(ADDR_STREAM_OPTS, 8'h80);
        chk({ssel, am}, 2'b11);
        cmd(0);
        @(negedge clk);
        chk({ssel, am, cust}, 3'b000);
        rdc(ADDR_IO_CFG2, 8'h5A);
        rdc(ADDR_STREAM_OPTS, 8'h00);
        $display("test default done");
    endtask
    task t_sub;
        int i;
        rxq.delete();
        wr(ADDR_MODE_SEL, 8'h70);
        wr(ADDR_STREAM_OPTS, 8'h30);
        half = 6'd16;
        en = 1'b1;
        for (i = 0; i < 600 && irs !== 1'b1; i++) @(negedge clk);
        chk({irs, act}, 2'b11);
        repeat (125) @(negedge clk);
        for (i = 2; i < 8; i++) begin
            en = i[0] ^ (i > 3); // bits 2..7 of 8'h5B
            repeat (128) @(negedge clk);
        end
        en = 1'b0;
        for (i = 0; i < 1400 && ire !== 1'b1; i++) @(negedge clk);
        chk({ire, act}, 2'b10);
        repeat (4) @(negedge clk);
        chk(8'(rxq.size()), 8'h02);
        chk(rxq[0], 8'h5B);
        chk(rxq[1], 8'h00);
        $display("test subcarrier done");
    endtask
    task t_bpsk;
        int i;
        logic [8:0] pat;
        pat = 9'h134;
        wr(ADDR_MODE_SEL, 8'h78);
        wr(ADDR_STREAM_OPTS, 8'h28);
        half = 6'd4;
        en = 1'b1;
        for (i = 0; i < 200 && irs !== 1'b1; i++) @(negedge clk);
        repeat (13) @(negedge clk);
        en = 1'b0;
        repeat (32) @(negedge clk);
        rxq.delete();
        en = 1'b1;
        for (i = 0; i < 200 && irs !== 1'b1; i++) @(negedge clk);
        chk(irs, 1'b1);
        repeat (5) @(negedge clk);
        for (i = 2; i < 9; i++) begin
            inv = pat[i];
            repeat (16) @(negedge clk);
        end
        repeat (6) @(negedge clk);
        en = 1'b0;
        for (i = 0; i < 30 && ire !== 1'b1; i++) @(negedge clk);
        chk(ire, 1'b1);
        repeat (4) @(negedge clk);
        chk(8'(rxq.size()), 8'h02);
        chk(rxq[0], pat[7:0]);
        chk(rxq[1], {7'h00, pat[8]});
        $display("test bpsk done");
    endtask
    task t_tx;
        int i, j, n;
        logic [15:0] b;
        b = 16'h3CA5;
        wr(ADDR_MODE_SEL, 8'h70);
        for (j = 0; j < 2; j++) begin
            n = 128 >> (3 * j);
            wr(ADDR_STREAM_OPTS, j ? 8'h03 : 8'h80);
            chk(am, 8'(j == 0));
            txq.push_back(b[7:0]);
            txq.push_back(b[15:8]);
            cmd(j + 1);
            for (i = 0; i < 8 && fifo_rd !== 1'b1; i++) @(negedge clk);
            repeat (n / 2) @(negedge clk);
            for (i = 0; i < 16; i++) begin
                chk(mod, b[i]);
                if (i < 15) repeat (n) @(negedge clk);
            end
            for (i = 0; i < n && ite !== 1'b1; i++) @(negedge clk);
            chk({ite, mod}, 2'b10);
        end
        $display("test transmit done");
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, dflt, crc, nocrc, en, inv, avail, popq} = 10'h000;
        {addr, half, wdata, fifo_d} = 28'h000_0000;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_dflt();
        t_sub();
        t_bpsk();
        t_tx();
        summarize();
    end
endmodule
